// >>> src/pp_pkg.sv
// ------------------------------------------------------------
// post-processor constants and carriers
// ------------------------------------------------------------
package pp_pkg;

  localparam int UNITS    = 4;
  localparam int SLOTS    = 16;
  localparam int SLOT_W   = 4;
  localparam int RES_W    = 12;
  localparam int SUM_W    = 14;
  localparam int CORR_W   = 10;
  localparam int CNT_W    = 12;
  localparam int EVT_W    = 12;
  localparam int EVT_UNIT = 3;

  localparam logic [RES_W-1:0] RES_MAX = 12'hFFF;
  localparam logic [SUM_W-1:0] SUM_MAX = 14'h0FFF;

  // per-unit register block, 32 bytes apart
  localparam logic [4:0] UOFF_CONFIG = 5'h00;
  localparam logic [4:0] UOFF_CORR   = 5'h04;
  localparam logic [4:0] UOFF_REF    = 5'h08;
  localparam logic [4:0] UOFF_RESULT = 5'h0C;
  localparam logic [4:0] UOFF_HIGH   = 5'h10;
  localparam logic [4:0] UOFF_LOW    = 5'h14;
  localparam logic [4:0] UOFF_STAMP  = 5'h18;

  // module-wide registers
  localparam logic [7:0] OFF_EVT_STATUS = 8'h80;
  localparam logic [7:0] OFF_EVT_CLEAR  = 8'h84;
  localparam logic [7:0] OFF_TRIP_SEL   = 8'h88;
  localparam logic [7:0] OFF_IRQ_SEL    = 8'h8C;
  localparam logic [7:0] OFF_COUNTER    = 8'h90;

  localparam int CFG_NEG_BIT   = 4;
  localparam int STAMP_DLY_LSB = 16;
  localparam int EVT_HIGH      = 0;
  localparam int EVT_LOW       = 1;
  localparam int EVT_ZERO      = 2;

  localparam logic [SLOT_W-1:0] SLOT_RESET = 4'h0;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [RES_W-1:0]  value;
  } pp_conv_type;

  typedef struct packed {
    logic [SLOT_W-1:0] sel;
    logic              negate;
    logic [CORR_W-1:0] corr;
    logic [RES_W-1:0]  refv;
    logic [31:0]       high;
    logic [31:0]       low;
    logic [31:0]       res;
    logic [CNT_W-1:0]  req;
    logic [CNT_W-1:0]  dly;
    logic              armed;
    logic              prev_neg;
  } pp_unit_type;

  typedef struct packed {
    pp_unit_type [UNITS-1:0]            unit;
    logic [SLOTS-1:0][RES_W-1:0]        slot_res;
    logic [EVT_W-1:0]                   stat;
    logic [EVT_W-1:0]                   trip_sel;
    logic [EVT_W-1:0]                   irq_sel;
    logic [EVT_W-1:0]                   trip;
    logic                               irq;
    logic [CNT_W-1:0]                   count;
    pp_conv_type                        out;
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
  } pp_state_type;

endpackage

// >>> src/pp_post_processor.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - four units per module, each selects any of sixteen slots
// - correction added to raw result, clamped to 0..4095, written to slot
// - zero correction passes the raw result unchanged
// - several units on one slot: highest-numbered unit's correction applies
// - after reset every unit selects slot zero
// - unit result is slot result minus reference, sign-extended to 32 bits
// - negate enable two's-complements the difference before storing
// - zero reference with negate off gives the slot result unchanged
// - reference write updates result at once; flags only at next eoc
// - each unit holds its own result register
// - result beyond high or low limit sets high or low trip flag
// - zero-cross flag set only at eoc whose sign differs from previous
// - a result of zero counts as positive
// - writing one to event clear clears matching flag
// - flag drives pwm trip output only when trip select bit set
// - irq-selected flags combine into one shared interrupt
// - free 12-bit counter increments each cycle, readable
// - slot trigger captures counter into request stamp
// - sample start stores counter minus request stamp as delay stamp
// - delay subtraction wraps modulo counter width
// - no capture on software trigger of own slot; others still counted
// - only the selected slot's eoc pulse evaluates the unit's flags
module pp_post_processor (
  input  logic                       pclk,          // system clock
  input  logic                       presetn,       // async reset, low
  input  logic                       psel,          // apb select
  input  logic                       penable,       // apb enable
  input  logic                       pwrite,        // apb direction
  input  logic [7:0]                 paddr,         // apb byte address
  input  logic [31:0]                pwdata,        // apb write data
  output logic [31:0]                prdata,        // apb read data
  output logic                       pready,        // apb ready
  output logic                       pslverr,       // apb error
  input  pp_pkg::pp_conv_type        eoc_in,        // raw result with eoc pulse
  input  logic [pp_pkg::SLOTS-1:0]   slot_trig,     // slot trigger pulses
  input  logic [pp_pkg::SLOTS-1:0]   slot_sw_trig,  // trigger came from software
  input  logic [pp_pkg::SLOTS-1:0]   slot_start,    // sample window begins
  output pp_pkg::pp_conv_type        result_out,    // corrected result write
  output logic [pp_pkg::EVT_W-1:0]   pwm_trip,      // trips to pwm module
  output logic                       shared_event_irq // shared interrupt
);

  pp_pkg::pp_state_type             st;
  pp_pkg::pp_state_type             next_st;
  logic                             setup;
  logic                             wr;
  logic                             dec_ok;
  logic [1:0]                       ui;
  logic [4:0]                       uo;
  logic [31:0]                      rd;
  logic [pp_pkg::EVT_W-1:0]         clr;
  logic [pp_pkg::EVT_W-1:0]         set;
  logic [pp_pkg::CORR_W-1:0]        cor;
  logic signed [pp_pkg::SUM_W-1:0]  sum;
  logic [pp_pkg::RES_W-1:0]         sv;
  logic signed [pp_pkg::SUM_W-1:0]  diff;
  logic [31:0]                      r32;
  logic                             hit;
  logic [pp_pkg::SLOT_W-1:0]        s;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    setup   = psel && !penable;
    ui      = paddr[6:5];
    uo      = paddr[4:0];
    rd      = 32'h0000_0000;
    clr     = '0;
    set     = '0;
    cor     = '0;
    sum     = '0;
    sv      = '0;
    diff    = '0;
    r32     = 32'h0000_0000;
    hit     = 1'b0;
    s       = '0;

    // apb decode and read capture in setup, answer in the access cycle
    if (paddr[7]) begin
      dec_ok = (paddr == pp_pkg::OFF_EVT_STATUS) || (paddr == pp_pkg::OFF_EVT_CLEAR)
            || (paddr == pp_pkg::OFF_TRIP_SEL) || (paddr == pp_pkg::OFF_IRQ_SEL)
            || (paddr == pp_pkg::OFF_COUNTER);
    end else begin
      dec_ok = (paddr[1:0] == 2'h0) && (uo <= pp_pkg::UOFF_STAMP);
    end
    if (paddr[7]) begin
      unique case (paddr)
        pp_pkg::OFF_EVT_STATUS: rd = 32'(st.stat);
        pp_pkg::OFF_TRIP_SEL:   rd = 32'(st.trip_sel);
        pp_pkg::OFF_IRQ_SEL:    rd = 32'(st.irq_sel);
        pp_pkg::OFF_COUNTER:    rd = 32'(st.count);
        default:                rd = 32'h0000_0000;
      endcase
    end else begin
      unique case (uo)
        pp_pkg::UOFF_CONFIG: begin
          rd = 32'(st.unit[ui].sel);
          rd[pp_pkg::CFG_NEG_BIT] = st.unit[ui].negate;
        end
        pp_pkg::UOFF_CORR:   rd = 32'($signed(st.unit[ui].corr));
        pp_pkg::UOFF_REF:    rd = 32'(st.unit[ui].refv);
        pp_pkg::UOFF_RESULT: rd = st.unit[ui].res;
        pp_pkg::UOFF_HIGH:   rd = st.unit[ui].high;
        pp_pkg::UOFF_LOW:    rd = st.unit[ui].low;
        pp_pkg::UOFF_STAMP: begin
          rd = 32'(st.unit[ui].req);
          rd[pp_pkg::STAMP_DLY_LSB +: pp_pkg::CNT_W] = st.unit[ui].dly;
        end
        default:             rd = 32'h0000_0000;
      endcase
    end
    next_st.pready  = setup;
    next_st.pslverr = setup && !dec_ok;
    if (setup) begin
      next_st.prdata = dec_ok ? rd : 32'h0000_0000;
    end
    wr = psel && penable && st.pready && pwrite && !st.pslverr;

    // register writes; read-only offsets accept and ignore data
    if (wr && paddr[7]) begin
      unique case (paddr)
        pp_pkg::OFF_EVT_CLEAR: clr = pwdata[pp_pkg::EVT_W-1:0];
        pp_pkg::OFF_TRIP_SEL:  next_st.trip_sel = pwdata[pp_pkg::EVT_W-1:0];
        pp_pkg::OFF_IRQ_SEL:   next_st.irq_sel = pwdata[pp_pkg::EVT_W-1:0];
        default: ;
      endcase
    end else if (wr) begin
      unique case (uo)
        pp_pkg::UOFF_CONFIG: begin
          next_st.unit[ui].sel    = pwdata[pp_pkg::SLOT_W-1:0];
          next_st.unit[ui].negate = pwdata[pp_pkg::CFG_NEG_BIT];
        end
        pp_pkg::UOFF_CORR: next_st.unit[ui].corr = pwdata[pp_pkg::CORR_W-1:0];
        pp_pkg::UOFF_REF:  next_st.unit[ui].refv = pwdata[pp_pkg::RES_W-1:0];
        pp_pkg::UOFF_HIGH: next_st.unit[ui].high = pwdata;
        pp_pkg::UOFF_LOW:  next_st.unit[ui].low  = pwdata;
        default: ;
      endcase
    end

    next_st.count = st.count + 12'h001;

    for (int u = 0; u < pp_pkg::UNITS; u++) begin
      if (st.unit[u].sel == eoc_in.slot) begin
        cor = st.unit[u].corr;
      end
    end
    // signed add with saturation; zero adds nothing
    sum = $signed({2'b00, eoc_in.value}) + $signed(pp_pkg::SUM_W'($signed(cor)));
    next_st.out.valid = eoc_in.valid;
    if (eoc_in.valid) begin
      next_st.out.slot = eoc_in.slot;
      if (sum < 0) begin
        next_st.out.value = '0;
      end else if (sum > $signed(pp_pkg::SUM_MAX)) begin
        next_st.out.value = pp_pkg::RES_MAX;
      end else begin
        next_st.out.value = sum[pp_pkg::RES_W-1:0];
      end
      next_st.slot_res[eoc_in.slot] = next_st.out.value;
    end

    for (int u = 0; u < pp_pkg::UNITS; u++) begin
      // difference against reference; zero reference passes
      sv   = next_st.slot_res[next_st.unit[u].sel];
      diff = $signed({2'b00, sv}) - $signed({2'b00, next_st.unit[u].refv});
      if (next_st.unit[u].negate) begin
        diff = -diff;
      end
      r32 = 32'(diff);
      next_st.unit[u].res = r32;
      // flags evaluated only at own slot's eoc
      hit = eoc_in.valid && (eoc_in.slot == next_st.unit[u].sel);
      if (hit) begin
        set[u*pp_pkg::EVT_UNIT + pp_pkg::EVT_HIGH] = $signed(r32) > $signed(st.unit[u].high);
        set[u*pp_pkg::EVT_UNIT + pp_pkg::EVT_LOW]  = $signed(r32) < $signed(st.unit[u].low);
        set[u*pp_pkg::EVT_UNIT + pp_pkg::EVT_ZERO] = r32[31] != st.unit[u].prev_neg;
        next_st.unit[u].prev_neg = r32[31];
      end

      // delay capture; a start in the trigger cycle gives zero
      s = st.unit[u].sel;
      if (slot_trig[s]) begin
        // capture request stamp; software trigger disarms
        if (!slot_sw_trig[s]) begin
          next_st.unit[u].req = st.count;
        end
        next_st.unit[u].armed = !slot_sw_trig[s];
      end
      if (slot_start[s] && next_st.unit[u].armed) begin
        next_st.unit[u].dly   = st.count - next_st.unit[u].req;
        next_st.unit[u].armed = 1'b0;
      end
    end

    next_st.stat = (st.stat & ~clr) | set;
    next_st.trip = next_st.stat & next_st.trip_sel;
    next_st.irq  = |(next_st.stat & next_st.irq_sel);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // all units start on slot zero
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign result_out       = st.out;
  assign pwm_trip         = st.trip;
  assign shared_event_irq = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic all_corr_zero;
  assign all_corr_zero = (st.unit[0].corr == '0) && (st.unit[1].corr == '0)
                      && (st.unit[2].corr == '0) && (st.unit[3].corr == '0);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence clear0_s;
    wr && (paddr == pp_pkg::OFF_EVT_CLEAR) && pwdata[0] && !eoc_in.valid;
  endsequence

  sequence unit0_eoc_s;
    eoc_in.valid && (eoc_in.slot == next_st.unit[0].sel);
  endsequence

  apb_answer_a: assert property (setup_s |=> pready)
    else $error("apb access not answered in one cycle");

  zero_pass_a: assert property (eoc_in.valid && all_corr_zero
    |=> result_out.valid && result_out.value == $past(eoc_in.value)
        && result_out.slot == $past(eoc_in.slot))
    else $error("raw result altered with zero correction");

  count_step_a: assert property (presetn |=> st.count == $past(st.count) + 12'h001)
    else $error("free counter did not step");

  ref_zero_a: assert property (st.unit[0].refv == '0 && !st.unit[0].negate
    |-> st.unit[0].res == 32'(st.slot_res[st.unit[0].sel]))
    else $error("unit result differs from slot with zero reference");

  negate_a: assert property (st.unit[1].negate
    |-> st.unit[1].res == 32'(-($signed({2'b00, st.slot_res[st.unit[1].sel]})
        - $signed({2'b00, st.unit[1].refv}))))
    else $error("negated unit result wrong");

  flag_eoc_a: assert property (!eoc_in.valid |=> (st.stat & ~$past(st.stat)) == '0)
    else $error("flag set without end of conversion");

  clear_a: assert property (clear0_s |=> !st.stat[0])
    else $error("event flag not cleared");

  sticky_a: assert property (st.stat[0] && !(wr && paddr == pp_pkg::OFF_EVT_CLEAR
    && pwdata[0]) |=> st.stat[0])
    else $error("event flag dropped without clear");

  trip_gate_a: assert property (pwm_trip[0] |-> st.stat[0] && st.trip_sel[0])
    else $error("trip output without enabled flag");

  irq_gate_a: assert property (shared_event_irq |-> |(st.stat & st.irq_sel))
    else $error("interrupt without enabled flag");

  delay_a: assert property (slot_start[st.unit[0].sel] && st.unit[0].armed
    && !slot_trig[st.unit[0].sel]
    |=> st.unit[0].dly == $past(st.count) - $past(st.unit[0].req) && !st.unit[0].armed)
    else $error("delay stamp wrong");

  req_capture_a: assert property (slot_trig[st.unit[0].sel]
    && !slot_sw_trig[st.unit[0].sel] && !slot_start[st.unit[0].sel]
    |=> st.unit[0].req == $past(st.count) && st.unit[0].armed)
    else $error("request stamp not captured");

  sw_disarm_a: assert property (slot_trig[st.unit[0].sel]
    && slot_sw_trig[st.unit[0].sel]
    |=> !st.unit[0].armed && st.unit[0].req == $past(st.unit[0].req))
    else $error("software trigger armed delay capture");

  set_wins_a: assert property ((|set) |=> (st.stat & $past(set)) == $past(set))
    else $error("event flag lost to same-cycle clear");

  top_unit_a: assert property (eoc_in.valid && st.unit[3].sel == eoc_in.slot
    && st.unit[3].corr == '0 |=> result_out.value == $past(eoc_in.value))
    else $error("highest unit correction not applied");

  clamp_high_a: assert property (eoc_in.valid && eoc_in.value == pp_pkg::RES_MAX
    && !cor[pp_pkg::CORR_W-1] |=> result_out.value == pp_pkg::RES_MAX)
    else $error("corrected result not clamped high");

  clamp_low_a: assert property (eoc_in.valid && eoc_in.value == '0
    && cor[pp_pkg::CORR_W-1] |=> result_out.value == '0)
    else $error("corrected result not clamped low");

  slot_write_a: assert property (eoc_in.valid
    |=> st.slot_res[$past(eoc_in.slot)] == result_out.value)
    else $error("slot result not written");

  eoc_slot_a: assert property (eoc_in.valid
    |=> result_out.valid && result_out.slot == $past(eoc_in.slot))
    else $error("result write missing after end of conversion");

  zero_cross_a: assert property (unit0_eoc_s
    ##0 (next_st.unit[0].res[31] != st.unit[0].prev_neg) |=> st.stat[pp_pkg::EVT_ZERO])
    else $error("zero crossing not flagged");

  zero_positive_a: assert property (unit0_eoc_s
    ##0 (next_st.unit[0].res == 32'h0000_0000) |=> !st.unit[0].prev_neg)
    else $error("zero result taken as negative");

  high_trip_a: assert property (unit0_eoc_s
    ##0 ($signed(next_st.unit[0].res) > $signed(st.unit[0].high))
    |=> st.stat[pp_pkg::EVT_HIGH])
    else $error("high limit not flagged");

  low_trip_a: assert property (unit0_eoc_s
    ##0 ($signed(next_st.unit[0].res) < $signed(st.unit[0].low))
    |=> st.stat[pp_pkg::EVT_LOW])
    else $error("low limit not flagged");

endmodule

// >>> verification/pp_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module pp_core_model (
  input  logic                pclk,         // system clock
  output pp_pkg::pp_conv_type eoc_in,       // eoc pulse with raw value
  output logic [15:0]         slot_trig,    // trigger pulses
  output logic [15:0]         slot_sw_trig, // software qualifier
  output logic [15:0]         slot_start    // sample window pulses
);
  initial begin
    eoc_in = '0;
    slot_trig = '0;
    slot_sw_trig = '0;
    slot_start = '0;
  end
  task automatic convert(input logic [3:0] s, input logic [11:0] v);
    @(posedge pclk);
    eoc_in <= '{1'b1, s, v};
    @(posedge pclk);
    // released bus shows junk, never the old value
    eoc_in <= '{1'b0, ~s, ~v};
  endtask
  // qualifier rides with its own slot only
  task automatic trigger(input logic [3:0] s, input logic sw);
    @(posedge pclk);
    slot_trig <= 16'h0001 << s;
    slot_sw_trig <= sw ? 16'h0001 << s : 16'h0000;
    @(posedge pclk);
    slot_trig <= '0;
    slot_sw_trig <= '0;
  endtask
  task automatic start(input logic [3:0] s);
    @(posedge pclk);
    slot_start <= 16'h0001 << s;
    @(posedge pclk);
    slot_start <= '0;
  endtask
endmodule

// >>> verification/adc_result_post_processor_tb.sv
`timescale 1ns/1ps
module adc_result_post_processor_tb;
  logic                pclk = 0;
  logic                presetn = 0;
  logic                psel = 0;
  logic                penable = 0;
  logic                pwrite = 0;
  logic [7:0]          paddr = '0;
  logic [31:0]         pwdata = '0;
  logic [31:0]         prdata;
  logic [31:0]         rq;
  logic                pready;
  logic                pslverr;
  logic                rerr;
  logic                shared_event_irq;
  pp_pkg::pp_conv_type eoc_in;
  pp_pkg::pp_conv_type result_out;
  logic [15:0]         trig;
  logic [15:0]         swq;
  logic [15:0]         start;
  logic [11:0]         pwm_trip;
  logic [11:0]         stat = '0;
  logic [11:0]         tsel = '0;
  logic [11:0]         isel = '0;
  int                  bad_count = 0;
  int                  compares = 0;
  int                  seed = 97692;
  int                  sres[16];
  int                  sel[4];
  int                  neg[4];
  int                  corr[4];
  int                  rf[4];
  int                  hi[4];
  int                  lo[4];
  int                  pneg[4];

  always #50 pclk = ~pclk;

  pp_core_model core (.pclk(pclk), .eoc_in(eoc_in), .slot_trig(trig),
    .slot_sw_trig(swq), .slot_start(start));
  pp_post_processor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eoc_in(eoc_in),
    .slot_trig(trig), .slot_sw_trig(swq), .slot_start(start),
    .result_out(result_out), .pwm_trip(pwm_trip),
    .shared_event_irq(shared_event_irq));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] ua(int u, logic [4:0] o);
    return 8'(u * 32) + {3'h0, o};
  endfunction
  function automatic int ures(int u);
    int d;
    d = sres[sel[u]] - rf[u];
    return neg[u] ? -d : d;
  endfunction
  task automatic cfg(int u);
    sel[u] = {$random(seed)} % 4;
    neg[u] = {$random(seed)} % 2;
    corr[u] = ($random(seed) % 4 == 0) ? 0 : $random(seed) % 512;
    rf[u] = ($random(seed) % 4 == 0) ? 0 : {$random(seed)} % 4096;
    hi[u] = $random(seed) % 2500;
    lo[u] = $random(seed) % 2500;
    wr(ua(u, pp_pkg::UOFF_CONFIG), 32'(neg[u] * 16 + sel[u]));
    wr(ua(u, pp_pkg::UOFF_CORR), 32'(corr[u]));
    wr(ua(u, pp_pkg::UOFF_REF), 32'(rf[u]));
    wr(ua(u, pp_pkg::UOFF_HIGH), 32'(hi[u]));
    wr(ua(u, pp_pkg::UOFF_LOW), 32'(lo[u]));
  endtask
  task automatic conv(int s, int v);
    int w;
    int c;
    int r;
    w = -1;
    for (int u = 0; u < 4; u++) if (sel[u] == s) w = u;
    c = v + (w < 0 ? 0 : corr[w]);
    c = c < 0 ? 0 : (c > 4095 ? 4095 : c);
    core.convert(4'(s), 12'(v));
    #1;
    chk("result valid", 1, result_out.valid);
    chk("corrected", c, result_out.value);
    sres[s] = c;
    for (int u = 0; u < 4; u++) begin
      r = ures(u);
      if (sel[u] == s) begin
        if (r > hi[u]) stat[3*u] = 1'b1;
        if (r < lo[u]) stat[3*u+1] = 1'b1;
        if (int'(r < 0) != pneg[u]) stat[3*u+2] = 1'b1;
        pneg[u] = int'(r < 0);
      end
    end
    chk("trip out", 32'(stat & tsel), pwm_trip);
    chk("irq", 32'(|(stat & isel)), shared_event_irq);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int t;
    int k;
    int gap;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int u = 0; u < 4; u++) begin
      rd(ua(u, pp_pkg::UOFF_CONFIG));
      chk("config", 0, rq);
    end
    rd(pp_pkg::OFF_COUNTER);
    t = rq;
    rd(pp_pkg::OFF_COUNTER);
    chk("count step", 3, (rq - t) & 32'hFFF);
    rd(8'hFC);
    chk("slverr", 1, rerr);
    $display("reset test done");
    for (int r = 0; r < 3; r++) begin
      tsel = 12'($random(seed));
      isel = 12'($random(seed));
      wr(pp_pkg::OFF_TRIP_SEL, {20'h0, tsel});
      wr(pp_pkg::OFF_IRQ_SEL, {20'h0, isel});
      for (int u = 0; u < 4; u++) cfg(u);
      for (int n = 0; n < 12; n++) begin
        t = n % 4 == 0 ? 0 : (n % 4 == 1 ? 4095 : {$random(seed)} % 4096);
        conv({$random(seed)} % 4, t);
        for (int u = 0; u < 4; u++) begin
          rd(ua(u, pp_pkg::UOFF_RESULT));
          chk("unit result", ures(u), rq);
        end
        rd(pp_pkg::OFF_EVT_STATUS);
        chk("status", 32'(stat), rq);
      end
    end
    $display("conversion test done");
    rf[0] = (rf[0] + 2000) % 4096;
    wr(ua(0, pp_pkg::UOFF_REF), 32'(rf[0]));
    rd(ua(0, pp_pkg::UOFF_RESULT));
    chk("new ref result", ures(0), rq);
    rd(pp_pkg::OFF_EVT_STATUS);
    chk("status held", 32'(stat), rq);
    t = {$random(seed)} % 4096;
    wr(pp_pkg::OFF_EVT_CLEAR, 32'(t));
    stat = stat & ~t[11:0];
    // read-only status ignores the write
    wr(pp_pkg::OFF_EVT_STATUS, 32'hFFF);
    rd(pp_pkg::OFF_EVT_STATUS);
    chk("cleared", 32'(stat), rq);
    rd(pp_pkg::OFF_EVT_CLEAR);
    chk("clear reads", 0, rq);
    chk("trip after clear", 32'(stat & tsel), pwm_trip);
    chk("irq after clear", 32'(|(stat & isel)), shared_event_irq);
    $display("event test done");
    sel[0] = 5;
    wr(ua(0, pp_pkg::UOFF_CONFIG), 32'h5);
    // at least one idle cycle so a wrongly armed software trigger shows
    k = 1 + {$random(seed)} % 20;
    rd(pp_pkg::OFF_COUNTER);
    t = rq;
    // park the request stamp near the top so the delay wraps
    gap = (4090 - t + 4096) % 4096;
    repeat (gap) @(posedge pclk);
    core.trigger(4'h5, 1'b0);
    repeat (k) @(posedge pclk);
    core.trigger(4'h6, 1'b1);
    core.start(4'h5);
    rd(ua(0, pp_pkg::UOFF_STAMP));
    chk("delay", k + 4, 32'(rq[27:16]));
    chk("request stamp", (t + gap + 3) % 4096, 32'(rq[11:0]));
    core.trigger(4'h5, 1'b1);
    core.start(4'h5);
    rd(ua(0, pp_pkg::UOFF_STAMP));
    chk("delay kept", k + 4, 32'(rq[27:16]));
    $display("stamp test done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end
endmodule
